// ### dv/i2c_seq_checker.sv
`timescale 1ns/100ps
module i2c_seq_checker (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sclOut,
    input wire logic        sclOe,
    input wire logic        sdaOut,
    input wire logic        sdaOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_pins_low_only: assert property (!sclOut && !sdaOut)
        else $error("pin output not low");
    a_reset_quiet: assert property ($past(srst) |-> !sclOe && !sdaOe)
        else $error("line pulled right after reset");
    a_stretch_hold: assert property (!sclOe && !sclIn |=> !sclOe)
        else $error("clock pulled while stretched");
    // Sync latency adds to the rollover, so five is a safe floor
    a_high_time: assert property ($fell(sclOe) |-> !sclOe[*5])
        else $error("clock high time too short");
    // Bench never programs a reload below three
    a_low_time: assert property ($rose(sclOe) |-> sclOe[*4])
        else $error("clock low time too short");
    a_start_edge: assert property ($rose(sdaOe) && !sclOe |-> sclIn)
        else $error("data pulled with clock low but not held");
    a_release_low: assert property ($fell(sdaOe) |-> sclOe)
        else $error("data released while clock high");
    a_collide_quiet: assert property (
        !sclIn && !sdaIn && !sclOe && !sdaOe |=> !sclOe && !sdaOe)
        else $error("lines pulled while bus held by another");
endmodule // i2c_seq_checker

bind i2c_master_bit_sequencer i2c_seq_checker chk_i (.clk, .srst,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .sclIn, .sdaIn, .sclOut, .sclOe, .sdaOut, .sdaOe);

// ### dv/i2c_slave_model.sv
`timescale 1ns/100ps
module i2c_slave_model (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       nack,
    input  wire logic [3:0] stretch,
    output logic            sclPull,
    output logic            sdaPull
);
    logic       sclQ = 1'b1;
    logic       sdaQ = 1'b1;
    logic [3:0] bits = 4'h0;
    logic [3:0] hold = 4'h0;
    initial sdaPull = 1'b0;
    assign sclPull = (hold != 4'h0);
    // Plain always: sdaPull also takes its power-up level from an initial
    always @(posedge clk) begin
        sclQ <= scl;
        sdaQ <= sda;
        if (hold != 4'h0)
            hold <= hold - 4'h1;
        if (sclQ && scl && sdaQ && !sda) begin
            bits <= 4'h0;
        end else if (!sclQ && scl) begin
            bits <= bits + 4'h1;
        end else if (sclQ && !scl) begin
            // Stretching hides the master's release from its own sampler
            hold <= stretch;
            sdaPull <= (bits == 4'h8) && !nack;
            if (bits == 4'h9)
                bits <= 4'h0;
        end
    end
endmodule // i2c_slave_model

// ### dv/test_i2c_master_bit_sequencer.sv
`timescale 1ns/100ps
module test_i2c_master_bit_sequencer;
    logic        clk, srst, read, write, mark, waitrequest;
    logic        sclOe, sdaOe, sclOut, sdaOut, sclW, sdaW, sclD, sdaD;
    logic        nack, tbScl, tbSda, slvScl, slvSda, sdaRise;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rv;
    logic [3:0]  stretch;
    logic [7:0]  txByte, wireByte;
    logic [31:0] expQ[$];
    logic [7:0]  byteQ[$];
    int          failures, checks, wireBits, cyc, lastRise;
    assign sclW = !(sclOe || slvScl || tbScl);
    assign sdaW = !(sdaOe || slvSda || tbSda);
    i2c_master_bit_sequencer i2c_master_bit_sequencer_i (.clk, .srst,
        .address, .read, .write, .writedata, .readdata, .waitrequest,
        .sclIn(sclW), .sdaIn(sdaW), .sclOut, .sclOe, .sdaOut, .sdaOe);
    i2c_slave_model i2c_slave_model_i (.clk, .scl(sclW), .sda(sdaW),
        .nack, .stretch, .sclPull(slvScl), .sdaPull(slvSda));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic rd, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        mark <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expQ.push_back(e);
        mark <= 1'b1;
        bus(1'b1, a, 32'h0);
    endtask
    // Polling reads are not noted, only the final state is compared
    task automatic wait_flag(input logic [31:0] m);
        int n;
        // A stale read value must not end the poll before the first read
        rv = '0;
        for (n = 0; n < 400 && (rv & m) !== m; n++)
            bus(1'b1, i2c_seq_pkg::FLAG_OFS, 32'h0);
        if (n >= 400) begin
            failures++;
            wrap_up();
        end
    endtask
    always @(posedge clk)
        if (read && mark && waitrequest === 1'b0 && expQ.size() > 0)
            check(readdata, expQ.pop_front());
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sclD <= sclW;
        sdaD <= sdaW;
        if (sclD && sclW && sdaD && !sdaW) begin
            wireBits <= 0;
        end else if (!sclD && sclW) begin
            // Ninth rise closes the byte; no start comes between bytes
            wireBits <= (wireBits == 8) ? 0 : wireBits + 1;
            wireByte <= {wireByte[6:0], sdaW};
            sdaRise <= sdaW;
            lastRise <= cyc;
            if (wireBits == 8 && byteQ.size() > 0)
                check({24'h0, wireByte}, {24'h0, byteQ.pop_front()});
            if (wireBits inside {[1:7]} && stretch == 4'h0)
                check({31'h0, cyc - lastRise inside {[8:14]}}, 32'h1);
        end else if (sclD && !sclW && wireBits inside {[1:8]}) begin
            check({31'h0, sdaD}, {31'h0, sdaRise});
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {srst, read, write, mark, nack, tbScl, tbSda} = 7'h40;
        {address, writedata, stretch, rv} = '0;
        {failures, checks, wireBits, cyc, lastRise} = '0;
        void'($urandom(58813));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(i2c_seq_pkg::RELOAD_OFS, {25'h0, i2c_seq_pkg::RELOAD_RST});
        rd(5'h14, 32'h0);
        bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h1);
        bus(1'b0, i2c_seq_pkg::TXBUF_OFS, 32'hA5);
        bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h2);
        rd(i2c_seq_pkg::FLAG_OFS, 32'h1);
        wait_flag(32'h4);
        rd(i2c_seq_pkg::CTRL2_OFS, 32'h0);
        rd(i2c_seq_pkg::STAT_OFS, 32'h8);
        rd(i2c_seq_pkg::FLAG_OFS, 32'h5);
        bus(1'b0, i2c_seq_pkg::FLAG_OFS, 32'h7);
        bus(1'b0, i2c_seq_pkg::RELOAD_OFS, 32'h3);
        $display("start test done");
        for (int i = 0; i < 3; i++) begin
            txByte = 8'($urandom);
            nack <= (i == 2);
            stretch <= (i == 1) ? 4'hC : 4'h0;
            byteQ.push_back(txByte);
            bus(1'b0, i2c_seq_pkg::TXBUF_OFS, {24'h0, txByte});
            rd(i2c_seq_pkg::STAT_OFS, 32'h9);
            bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h2);
            wait_flag(32'h4);
            rd(i2c_seq_pkg::CTRL2_OFS, (i == 2) ? 32'h40 : 32'h0);
            rd(i2c_seq_pkg::STAT_OFS, 32'h8);
            rd(i2c_seq_pkg::FLAG_OFS, 32'h4);
            bus(1'b0, i2c_seq_pkg::FLAG_OFS, 32'h7);
        end
        $display("byte test done");
        bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h2);
        bus(1'b0, i2c_seq_pkg::TXBUF_OFS, 32'h3C);
        bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h1);
        wait_flag(32'h4);
        rd(i2c_seq_pkg::CTRL2_OFS, 32'h40);
        rd(i2c_seq_pkg::STAT_OFS, 32'h8);
        rd(i2c_seq_pkg::FLAG_OFS, 32'h5);
        $display("repeated start test done");
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        tbScl <= 1'b1;
        tbSda <= 1'b1;
        @(posedge clk);
        bus(1'b0, i2c_seq_pkg::CTRL2_OFS, 32'h1);
        wait_flag(32'h2);
        rd(i2c_seq_pkg::CTRL2_OFS, 32'h0);
        rd(i2c_seq_pkg::FLAG_OFS, 32'h2);
        $display("collision test done");
        wrap_up();
    end
endmodule // test_i2c_master_bit_sequencer

// ### hdl/i2c_master_bit_sequencer.sv
`timescale 1ns/100ps

module i2c_master_bit_sequencer (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sclOut,
    output logic             sclOe,
    output logic             sdaOut,
    output logic             sdaOe
);

    i2c_seq_pkg::seq_state_t state_r;
    i2c_seq_pkg::lines_t     syncA_r;
    i2c_seq_pkg::lines_t     syncB_r;
    i2c_seq_pkg::lines_t     hold_r;
    i2c_seq_pkg::flags_t     flags_r;
    i2c_seq_pkg::flags_t     evt_r;
    logic [6:0]              cnt_r;
    logic [6:0]              reload_r;
    logic [7:0]              shift_r;
    logic [3:0]              bit_r;
    logic                    sen_r;
    logic                    repeated_start_enable_bit_r;
    logic                    bf_r;
    logic                    acknowledge_status_bit_r;
    logic                    startSeen_r;
    logic                    ack_r;
    logic [31:0]             rdata_r;
    logic                    zero;
    logic                    busy;
    logic                    wrStb;
    logic                    ctrlWr;
    logic                    bufWr;
    logic                    sclS;
    logic                    sdaS;
    logic [31:0]             rdMux;

    // Pins come from the open bus, so two flops before any use
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA_r <= '1;
            syncB_r <= '1;
        end else begin
            syncA_r <= {sclIn, sdaIn};
            syncB_r <= syncA_r;
        end
    end

    assign sclS = syncB_r.scl;
    assign sdaS = syncB_r.sda;

    // Open drain: output level is always low, enable marks a drive
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe  = hold_r.scl;
    assign sdaOe  = hold_r.sda;

    // One wait cycle on every access; the access acts when ack_r is high
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read | write) & ~ack_r;
        end
    end

    assign waitrequest = (read | write) & ~ack_r;
    assign wrStb       = write & ack_r;
    assign ctrlWr      = wrStb & (address == i2c_seq_pkg::CTRL2_OFS);
    assign bufWr       = wrStb & (address == i2c_seq_pkg::TXBUF_OFS);
    assign busy        = (state_r != i2c_seq_pkg::IDLE) | sen_r | repeated_start_enable_bit_r;
    assign zero        = (cnt_r == i2c_seq_pkg::CNT_RST);

    always_comb begin
        rdMux = '0;
        unique case (address)
            i2c_seq_pkg::CTRL2_OFS: begin
                rdMux[i2c_seq_pkg::SEN_BIT]     = sen_r;
                rdMux[i2c_seq_pkg::REPEATED_START_ENABLE_BIT_BIT]    = repeated_start_enable_bit_r;
                rdMux[i2c_seq_pkg::ACKNOWLEDGE_STATUS_BIT_BIT] = acknowledge_status_bit_r;
            end
            i2c_seq_pkg::STAT_OFS: begin
                rdMux[i2c_seq_pkg::BF_BIT]    = bf_r;
                rdMux[i2c_seq_pkg::START_BIT] = startSeen_r;
            end
            i2c_seq_pkg::TXBUF_OFS:  rdMux[7:0] = shift_r;
            i2c_seq_pkg::RELOAD_OFS: rdMux[6:0] = reload_r;
            i2c_seq_pkg::FLAG_OFS: begin
                rdMux[i2c_seq_pkg::WRITE_COLLISION_FLAG_BIT] = flags_r.write_collision_flag;
                rdMux[i2c_seq_pkg::BCL_BIT]  = flags_r.bcl;
                rdMux[i2c_seq_pkg::IRQ_BIT]  = flags_r.irq;
            end
            default: rdMux = '0;
        endcase
    end

    // Read data captured in the wait cycle, stands at the completing edge
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else if (read & ~ack_r) begin
            rdata_r <= rdMux;
        end
    end

    assign readdata = rdata_r;

    // Reload value is private to this instance
    always_ff @(posedge clk) begin
        if (srst) begin
            reload_r <= i2c_seq_pkg::RELOAD_RST;
        end else if (wrStb && address == i2c_seq_pkg::RELOAD_OFS) begin
            reload_r <= writedata[6:0];
        end
    end

    // Sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= '0;
        end else if (wrStb && address == i2c_seq_pkg::FLAG_OFS) begin
            flags_r.write_collision_flag <= evt_r.write_collision_flag |
                (flags_r.write_collision_flag & ~writedata[i2c_seq_pkg::WRITE_COLLISION_FLAG_BIT]);
            flags_r.bcl  <= evt_r.bcl |
                (flags_r.bcl & ~writedata[i2c_seq_pkg::BCL_BIT]);
            flags_r.irq  <= evt_r.irq |
                (flags_r.irq & ~writedata[i2c_seq_pkg::IRQ_BIT]);
        end else begin
            flags_r <= flags_r | evt_r;
        end
    end

    // Write collision: no event may be queued behind a running one
    always_ff @(posedge clk) begin
        if (srst) begin
            evt_r.write_collision_flag <= 1'b0;
        end else begin
            evt_r.write_collision_flag <= bufWr & busy;
        end
    end

    // Bus sequencer with its rate counter
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r     <= i2c_seq_pkg::IDLE;
            cnt_r       <= i2c_seq_pkg::CNT_RST;
            hold_r      <= '0;
            shift_r     <= '0;
            bit_r       <= '0;
            sen_r       <= 1'b0;
            repeated_start_enable_bit_r      <= 1'b0;
            bf_r        <= 1'b0;
            acknowledge_status_bit_r   <= 1'b0;
            startSeen_r <= 1'b0;
            evt_r.bcl   <= 1'b0;
            evt_r.irq   <= 1'b0;
        end else begin
            evt_r.bcl <= 1'b0;
            evt_r.irq <= 1'b0;
            if (!zero) begin
                cnt_r <= cnt_r - 7'h01;
            end
            if (ctrlWr && !busy) begin
                // Start takes priority when both enables are written
                if (writedata[i2c_seq_pkg::SEN_BIT]) begin
                    sen_r <= 1'b1;
                end else if (writedata[i2c_seq_pkg::REPEATED_START_ENABLE_BIT_BIT]) begin
                    repeated_start_enable_bit_r <= 1'b1;
                end
            end
            if (bufWr && !busy) begin
                shift_r <= writedata[7:0];
                bf_r    <= 1'b1;
                bit_r   <= '0;
                state_r <= i2c_seq_pkg::TX_FALL;
            end
            unique case (state_r)
                i2c_seq_pkg::IDLE: begin
                    if (sen_r && sclS && sdaS) begin
                        cnt_r   <= reload_r;
                        state_r <= i2c_seq_pkg::ST_WAIT;
                    end else if (sen_r && !sclS && !sdaS) begin
                        sen_r     <= 1'b0;
                        evt_r.bcl <= 1'b1;
                    end else if (repeated_start_enable_bit_r) begin
                        hold_r.scl <= 1'b1;
                        state_r    <= i2c_seq_pkg::RS_FALL;
                    end
                end
                i2c_seq_pkg::ST_WAIT: begin
                    if (!sclS || (zero && !sdaS)) begin
                        sen_r     <= 1'b0;
                        evt_r.bcl <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end else if (zero) begin
                        hold_r.sda  <= 1'b1;
                        startSeen_r <= 1'b1;
                        cnt_r       <= reload_r;
                        state_r     <= i2c_seq_pkg::ST_HOLD;
                    end
                end
                i2c_seq_pkg::ST_HOLD: begin
                    if (zero) begin
                        sen_r     <= 1'b0;
                        evt_r.irq <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end
                end
                i2c_seq_pkg::RS_FALL: begin
                    if (!sclS) begin
                        hold_r.sda <= 1'b0;
                        cnt_r      <= {1'b0, reload_r[5:0]};
                        state_r    <= i2c_seq_pkg::RS_SDAHI;
                    end
                end
                i2c_seq_pkg::RS_SDAHI: begin
                    if (zero && sdaS) begin
                        hold_r.scl <= 1'b0;
                        state_r    <= i2c_seq_pkg::RS_REL;
                    end else if (zero) begin
                        hold_r     <= '0;
                        repeated_start_enable_bit_r     <= 1'b0;
                        evt_r.bcl  <= 1'b1;
                        state_r    <= i2c_seq_pkg::IDLE;
                    end
                end
                i2c_seq_pkg::RS_REL: begin
                    // Counter stays stopped while a slave stretches the clock
                    if (sclS && !sdaS) begin
                        repeated_start_enable_bit_r    <= 1'b0;
                        evt_r.bcl <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end else if (sclS) begin
                        cnt_r   <= reload_r;
                        state_r <= i2c_seq_pkg::RS_HIGH;
                    end
                end
                i2c_seq_pkg::RS_HIGH: begin
                    if (!sclS || !sdaS) begin
                        repeated_start_enable_bit_r    <= 1'b0;
                        evt_r.bcl <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end else if (zero) begin
                        hold_r.sda  <= 1'b1;
                        startSeen_r <= 1'b1;
                        cnt_r       <= reload_r;
                        state_r     <= i2c_seq_pkg::RS_SDALOW;
                    end
                end
                i2c_seq_pkg::RS_SDALOW: begin
                    if (zero) begin
                        repeated_start_enable_bit_r    <= 1'b0;
                        evt_r.irq <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end
                end
                i2c_seq_pkg::TX_FALL: begin
                    hold_r.scl <= 1'b1;
                    if (!sclS && hold_r.scl) begin
                        // Data moves only once the clock is seen low
                        if (bit_r == i2c_seq_pkg::BIT_LAST) begin
                            hold_r.sda <= 1'b0;
                            bf_r       <= 1'b0;
                        end else begin
                            hold_r.sda <= ~shift_r[3'(7 - bit_r)];
                        end
                        cnt_r   <= reload_r;
                        state_r <= i2c_seq_pkg::TX_LOW;
                    end
                end
                i2c_seq_pkg::TX_LOW: begin
                    if (zero) begin
                        hold_r.scl <= 1'b0;
                        state_r    <= i2c_seq_pkg::TX_REL;
                    end
                end
                i2c_seq_pkg::TX_REL: begin
                    if (sclS) begin
                        cnt_r   <= reload_r;
                        state_r <= i2c_seq_pkg::TX_HIGH;
                    end
                end
                i2c_seq_pkg::TX_HIGH: begin
                    if (!hold_r.sda && !sdaS &&
                        bit_r != i2c_seq_pkg::BIT_LAST) begin
                        // Lost arbitration: another master drives a zero
                        hold_r    <= '0;
                        bf_r      <= 1'b0;
                        evt_r.bcl <= 1'b1;
                        state_r   <= i2c_seq_pkg::IDLE;
                    end else if (zero && bit_r == i2c_seq_pkg::BIT_LAST) begin
                        acknowledge_status_bit_r  <= sdaS;
                        hold_r.scl <= 1'b1;
                        evt_r.irq  <= 1'b1;
                        state_r    <= i2c_seq_pkg::IDLE;
                    end else if (zero) begin
                        bit_r      <= bit_r + 4'h1;
                        hold_r.scl <= 1'b1;
                        state_r    <= i2c_seq_pkg::TX_FALL;
                    end
                end
                default: state_r <= i2c_seq_pkg::IDLE;
            endcase
        end
    end

endmodule // i2c_master_bit_sequencer

// ### pkg/i2c_seq_pkg.sv
package i2c_seq_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] CTRL2_OFS  = 5'h00;
    localparam logic [4:0] STAT_OFS   = 5'h04;
    localparam logic [4:0] TXBUF_OFS  = 5'h08;
    localparam logic [4:0] RELOAD_OFS = 5'h0C;
    localparam logic [4:0] FLAG_OFS   = 5'h10;

    // Field positions
    localparam int SEN_BIT     = 0;
    localparam int REPEATED_START_ENABLE_BIT_BIT    = 1;
    localparam int ACKNOWLEDGE_STATUS_BIT_BIT = 6;
    localparam int BF_BIT      = 0;
    localparam int START_BIT   = 3;
    localparam int WRITE_COLLISION_FLAG_BIT    = 0;
    localparam int BCL_BIT     = 1;
    localparam int IRQ_BIT     = 2;
    localparam int SEQ_EN_W    = 5;

    // Values after reset, and the bit index of the acknowledge slot after a byte
    localparam logic [6:0] RELOAD_RST = 7'h18;
    localparam logic [6:0] CNT_RST    = 7'h00;
    localparam logic [3:0] BIT_LAST   = 4'h8;

    typedef enum logic [3:0] {
        IDLE      = 4'b0000,
        ST_WAIT   = 4'b0001,
        ST_HOLD   = 4'b0010,
        RS_FALL   = 4'b0011,
        RS_SDAHI  = 4'b0100,
        RS_REL    = 4'b0101,
        RS_HIGH   = 4'b0110,
        RS_SDALOW = 4'b0111,
        TX_FALL   = 4'b1000,
        TX_LOW    = 4'b1001,
        TX_REL    = 4'b1010,
        TX_HIGH   = 4'b1011
    } seq_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;

    typedef struct packed {
        logic irq;
        logic bcl;
        logic write_collision_flag;
    } flags_t;

endpackage
